// [design/itrs_pkg.sv]
// How it works
// RULE1: per-input polarity, 0 open, 1 closed
// RULE2: forward terminal polarity bit, default 0
// RULE3: normally-open: closed contact means asserted
// RULE4: normally-closed: open contact means asserted
// RULE5: reset-function input never inverted
// RULE6: code 0 forward run, code 1 reverse
// RULE7: forward alone runs forward, else stop
// RULE8: reverse alone runs reverse, else stop
// RULE9: forward and reverse together decode stop
// RULE10: closed-polarity run input open means running
// RULE11: codes 2 to 5 pick speed bits
// RULE12: four speed bits form index 0-15
// RULE13: index 1-15 selects stored preset frequency
// RULE14: index 0 selects operator or analog reference
// RULE15: each input has selector 0 to 40; the code stores any written 6-bit value, 0 to 63
// RULE16: inputs synchronised before polarity and decode
package itrs_pkg;

  localparam int unsigned NTERM   = 9;
  localparam int unsigned FWD_IDX = 8;
  localparam int unsigned FSEL_W  = 6;
  localparam int unsigned FREQ_W  = 16;
  localparam int unsigned NPRESET = 16;
  localparam int unsigned AW      = 8;

  localparam logic [FSEL_W-1:0] FN_FORWARD_RUN  = 6'h00;
  localparam logic [FSEL_W-1:0] FN_BACKWARD_RUN = 6'h01;
  localparam logic [FSEL_W-1:0] FN_SPEED_BIT0   = 6'h02;
  localparam logic [FSEL_W-1:0] FN_SPEED_BIT1   = 6'h03;
  localparam logic [FSEL_W-1:0] FN_SPEED_BIT2   = 6'h04;
  localparam logic [FSEL_W-1:0] FN_SPEED_BIT3   = 6'h05;
  localparam logic [FSEL_W-1:0] FN_RESET        = 6'h11;

  // selector reset values, terminal 1 in the low slot, forward terminal on top
  localparam logic [NTERM*FSEL_W-1:0] FUNC_RST = {6'h00, 6'h01, 6'h02, 6'h03, 6'h09,
                                                  6'h0b, 6'h06, 6'h10, 6'h11};
  localparam logic [NTERM-1:0]        POL_RST  = 9'h000;
  localparam logic                    SRC_RST  = 1'b0;
  localparam logic [FREQ_W-1:0]       FREQ_RST = 16'h0000;

  localparam logic [AW-1:0] OFS_POLARITY = 8'h00;
  localparam logic [AW-1:0] OFS_SOURCE   = 8'h04;
  localparam logic [AW-1:0] OFS_STATUS   = 8'h08;
  localparam logic [AW-1:0] OFS_FREQREF  = 8'h0c;
  localparam logic [AW-1:0] OFS_OPERFREQ = 8'h10;
  localparam logic [AW-1:0] OFS_FWDFUNC  = 8'h14;
  localparam logic [AW-1:0] OFS_FUNC     = 8'h20;
  localparam logic [AW-1:0] OFS_PRESET   = 8'h40;

  localparam int unsigned ST_RUN_LSB = 0;
  localparam int unsigned ST_IDX_LSB = 4;
  localparam int unsigned ST_RST_BIT = 8;
  localparam int unsigned ST_ACT_LSB = 16;

  typedef enum logic [1:0] {
    RUN_STOP     = 2'b00,
    RUN_FORWARD  = 2'b01,
    RUN_BACKWARD = 2'b10
  } itrs_run_e;

  typedef struct packed {
    logic       fwd_req;
    logic       rev_req;
    logic [3:0] speed_idx;
    logic       reset_req;
  } itrs_cmd_s;

endpackage : itrs_pkg

// [design/itrs_term_sync.sv]
`timescale 1ns/1ps
module itrs_term_sync
  import itrs_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             ce,
  input  wire logic [NTERM-1:0] raw,
  output logic      [NTERM-1:0] level
);

  logic [NTERM-1:0] s1_q;
  logic [NTERM-1:0] s2_q;
  logic [NTERM-1:0] s3_q;
  logic [NTERM-1:0] level_q;
  logic [NTERM-1:0] level_d;
  wire  [NTERM-1:0] agree = ~(s2_q ^ s3_q);

  // RULE16 agree filter
  assign level_d = (agree & s3_q) | (~agree & level_q);
  assign level   = level_q;

  // s1 feeds s2 only; a bit counts once two later stages agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q    <= '0;
      s2_q    <= '0;
      s3_q    <= '0;
      level_q <= '0;
    end else if (ce) begin
      s1_q    <= raw;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      level_q <= level_d;
    end
  end

  chk_sync_holds: assert property (@(posedge pclk) disable iff (!presetn) // RULE16
    (ce && (s2_q != s3_q)) |=> ((level_q & ~$past(agree)) == ($past(level_q) & ~$past(agree))))
    else $error("synchronised level moved while stages disagreed");

endmodule : itrs_term_sync

// [design/itrs_cmd_decode.sv]
`timescale 1ns/1ps
module itrs_cmd_decode
  import itrs_pkg::*;
(
  input  wire logic [NTERM-1:0]        level,
  input  wire logic [NTERM-1:0]        pol,
  input  wire logic [NTERM*FSEL_W-1:0] func,
  output logic      [NTERM-1:0]        active,
  output itrs_cmd_s                    cmd
);

  // any asserted input carrying the given function code
  function automatic logic fn_hits(input logic [NTERM*FSEL_W-1:0] f,
                                   input logic [NTERM-1:0]        a,
                                   input logic [FSEL_W-1:0]       code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NTERM; i++) begin
      hit = hit | (a[i] & (f[i*FSEL_W +: FSEL_W] == code));
    end
    return hit;
  endfunction : fn_hits

  logic [NTERM-1:0] is_reset;
  logic [NTERM-1:0] eff_pol;

  for (genvar g = 0; g < NTERM; g++) begin : g_term
    assign is_reset[g] = (func[g*FSEL_W +: FSEL_W] == FN_RESET);
  end

  // RULE5 reset stays open-type
  assign eff_pol = pol & ~is_reset;
  // RULE3 RULE4 RULE10 polarity apply
  assign active  = level ^ eff_pol;

  // RULE6 RULE15 run code match
  assign cmd.fwd_req      = fn_hits(func, active, FN_FORWARD_RUN);
  assign cmd.rev_req      = fn_hits(func, active, FN_BACKWARD_RUN);
  // RULE11 RULE12 speed bits
  assign cmd.speed_idx[0] = fn_hits(func, active, FN_SPEED_BIT0);
  assign cmd.speed_idx[1] = fn_hits(func, active, FN_SPEED_BIT1);
  assign cmd.speed_idx[2] = fn_hits(func, active, FN_SPEED_BIT2);
  assign cmd.speed_idx[3] = fn_hits(func, active, FN_SPEED_BIT3);
  assign cmd.reset_req    = fn_hits(func, active, FN_RESET);

endmodule : itrs_cmd_decode

// [design/itrs_top.sv]
`timescale 1ns/1ps
module itrs_top
  import itrs_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              ce,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [AW-1:0]     paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [NTERM-1:0]  terminal_closed,
  input  wire logic [FREQ_W-1:0] analog_freq_in,
  output itrs_run_e              run_state,
  output logic      [3:0]        speed_index,
  output logic      [FREQ_W-1:0] freq_ref,
  output logic                   reset_cmd,
  output logic      [NTERM-1:0]  terminal_active
);

  ////////////////////////////////////////////////////////////////////////////////
  // state

  logic [NTERM-1:0]        pol_q;
  logic                    src_q;
  logic [FREQ_W-1:0]       oper_q;
  logic [NTERM*FSEL_W-1:0] func_q;
  logic [FREQ_W-1:0]       preset_q [NPRESET];
  logic                    pready_q;
  logic [31:0]             prdata_q;
  logic                    pslverr_q;
  itrs_run_e               run_q;
  itrs_run_e               run_d;
  logic [3:0]              idx_q;
  logic [FREQ_W-1:0]       freq_q;
  logic [FREQ_W-1:0]       freq_d;
  logic                    rst_q;
  logic [NTERM-1:0]        act_q;

  logic [NTERM-1:0]        level;
  logic [NTERM-1:0]        active;
  itrs_cmd_s               cmd;

  ////////////////////////////////////////////////////////////////////////////////
  // terminal path

  // RULE16 synchronise pins
  itrs_term_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .raw     (terminal_closed),
    .level   (level)
  );

  itrs_cmd_decode u_dec (
    .level  (level),
    .pol    (pol_q),
    .func   (func_q),
    .active (active),
    .cmd    (cmd)
  );

  // RULE7 RULE8 RULE9 run decode
  assign run_d = (cmd.fwd_req && !cmd.rev_req) ? RUN_FORWARD  :
                 (cmd.rev_req && !cmd.fwd_req) ? RUN_BACKWARD : RUN_STOP;

  // RULE13 RULE14 reference select
  assign freq_d = (idx_q != 4'h0) ? preset_q[idx_q] :
                  (src_q ? analog_freq_in : oper_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q  <= RUN_STOP;
      idx_q  <= 4'h0;
      freq_q <= FREQ_RST;
      rst_q  <= 1'b0;
      act_q  <= '0;
    end else if (ce) begin
      run_q  <= run_d;
      idx_q  <= cmd.speed_idx;
      freq_q <= freq_d;
      rst_q  <= cmd.reset_req;
      act_q  <= active;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // apb slave, one wait state on every transfer
  // the wait state lets read data come from a flop; zero-wait reads would need it combinational

  wire acc_done  = psel & penable & pready_q;
  wire wr_en     = acc_done & pwrite;
  wire pready_d  = psel & penable & ~pready_q;
  wire hit_pol   = (paddr == OFS_POLARITY);
  wire hit_src   = (paddr == OFS_SOURCE);
  wire hit_stat  = (paddr == OFS_STATUS);
  wire hit_fref  = (paddr == OFS_FREQREF);
  wire hit_oper  = (paddr == OFS_OPERFREQ);
  wire hit_ffwd  = (paddr == OFS_FWDFUNC);
  wire hit_func  = (paddr[AW-1:5] == OFS_FUNC[AW-1:5]) && (paddr[1:0] == 2'b00);
  // preset slot 0 is never used: index 0 takes the main reference
  wire hit_pre   = (paddr[AW-1:6] == OFS_PRESET[AW-1:6]) && (paddr[5:2] != 4'h0)
                   && (paddr[1:0] == 2'b00);
  wire [2:0] fsel_idx = paddr[4:2];
  wire [3:0] pre_idx  = paddr[5:2];
  wire       mapped   = hit_pol | hit_src | hit_stat | hit_fref | hit_oper | hit_ffwd
                        | hit_func | hit_pre;

  logic [31:0] status_word;
  logic [31:0] rd_data;

  assign status_word = (32'(run_q) << ST_RUN_LSB) | (32'(idx_q) << ST_IDX_LSB)
                     | (32'(rst_q) << ST_RST_BIT) | (32'(act_q) << ST_ACT_LSB);

  assign rd_data = hit_pol  ? 32'(pol_q)  :
                   hit_src  ? 32'(src_q)  :
                   hit_stat ? status_word :
                   hit_fref ? 32'(freq_q) :
                   hit_oper ? 32'(oper_q) :
                   hit_ffwd ? 32'(func_q[FWD_IDX*FSEL_W +: FSEL_W]) :
                   hit_func ? 32'(func_q[fsel_idx*FSEL_W +: FSEL_W]) :
                   hit_pre  ? 32'(preset_q[pre_idx]) : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (ce) begin
      pready_q  <= pready_d;
      prdata_q  <= (pready_d && !pwrite) ? rd_data : 32'h0000_0000;
      pslverr_q <= pready_d & ~mapped;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // configuration registers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pol_q  <= POL_RST;
      src_q  <= SRC_RST;
      oper_q <= FREQ_RST;
      func_q <= FUNC_RST;
    end else if (ce && wr_en) begin
      // RULE1 RULE2 polarity write
      if (hit_pol) begin
        pol_q <= pwdata[NTERM-1:0];
      end
      if (hit_src) begin
        src_q <= pwdata[0];
      end
      if (hit_oper) begin
        oper_q <= pwdata[FREQ_W-1:0];
      end
      // RULE15 selector write
      if (hit_ffwd) begin
        func_q[FWD_IDX*FSEL_W +: FSEL_W] <= pwdata[FSEL_W-1:0];
      end
      if (hit_func) begin
        func_q[fsel_idx*FSEL_W +: FSEL_W] <= pwdata[FSEL_W-1:0];
      end
    end
  end

  // RULE13 preset storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NPRESET; i++) begin
        preset_q[i] <= FREQ_RST;
      end
    end else if (ce && wr_en && hit_pre) begin
      preset_q[pre_idx] <= pwdata[FREQ_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata          = prdata_q;
  assign pready          = pready_q;
  assign pslverr         = pslverr_q;
  assign run_state       = run_q;
  assign speed_index     = idx_q;
  assign freq_ref        = freq_q;
  assign reset_cmd       = rst_q;
  assign terminal_active = act_q;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_fwd_alone;
    ce && cmd.fwd_req && !cmd.rev_req;
  endsequence

  sequence s_rev_alone;
    ce && cmd.rev_req && !cmd.fwd_req;
  endsequence

  // access cycle still waiting for the slave
  sequence s_access_wait;
    ce && psel && penable && !pready_q;
  endsequence

  sequence s_frozen;
    !ce;
  endsequence

  // helpers so that $past sees a plain signal, not an indexed preset_q entry or a pwdata slice
  logic [FREQ_W-1:0] pre_pick;
  logic [NTERM-1:0]  wr_pol;
  logic [FREQ_W-1:0] wr_freq;

  assign pre_pick = preset_q[idx_q];
  assign wr_pol   = pwdata[NTERM-1:0];
  assign wr_freq  = pwdata[FREQ_W-1:0];

  chk_pol_reset_val: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
    $rose(presetn) |-> (pol_q[FWD_IDX-1:0] == POL_RST[FWD_IDX-1:0]))
    else $error("general polarity not open-type after reset");

  chk_fwd_pol_reset: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
    $rose(presetn) |-> (pol_q[FWD_IDX] == POL_RST[FWD_IDX]))
    else $error("forward polarity not open-type after reset");

  chk_term_polarity: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
    (ce && (func_q[FSEL_W-1:0] != FN_RESET))
      |=> (act_q[0] == ($past(level[0]) ^ $past(pol_q[0]))))
    else $error("terminal active level wrong for polarity");

  chk_reset_no_invert: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
    (ce && (func_q[FSEL_W-1:0] == FN_RESET) && pol_q[0]) |=> (act_q[0] == $past(level[0])))
    else $error("reset-function input was inverted");

  chk_run_forward: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
    s_fwd_alone |=> (run_q == RUN_FORWARD))
    else $error("forward command alone did not run forward");

  chk_run_backward: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
    s_rev_alone |=> (run_q == RUN_BACKWARD))
    else $error("reverse command alone did not run reverse");

  chk_both_stop: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
    (ce && (cmd.fwd_req == cmd.rev_req)) |=> (run_q == RUN_STOP))
    else $error("conflicting or absent run commands not decoded as stop");

  chk_speed_index: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
    ce |=> (idx_q == $past(cmd.speed_idx)))
    else $error("speed index not taken from select bits");

  chk_preset_select: assert property (@(posedge pclk) disable iff (!presetn) // RULE13
    (ce && (idx_q != 4'h0)) |=> (freq_q == $past(pre_pick)))
    else $error("preset frequency not selected");

  chk_main_reference: assert property (@(posedge pclk) disable iff (!presetn) // RULE14
    (ce && (idx_q == 4'h0)) |=> (freq_q == ($past(src_q) ? $past(analog_freq_in)
                                                       : $past(oper_q))))
    else $error("main reference not selected for index zero");

  chk_ready_after_wait: assert property (@(posedge pclk) disable iff (!presetn) // RULE15
    s_access_wait |=> pready_q)
    else $error("slave did not answer after one wait state");

  chk_ready_one_cycle: assert property (@(posedge pclk) disable iff (!presetn) // RULE15
    (ce && pready_q) |=> !pready_q)
    else $error("ready held longer than one cycle");

  chk_rdata_idle: assert property (@(posedge pclk) disable iff (!presetn) // RULE15
    !pready_q |-> (prdata_q == 32'h0000_0000))
    else $error("read data shown outside the ready cycle");

  chk_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn) // RULE13
    s_access_wait |=> (pslverr_q != $past(mapped)))
    else $error("error flag does not match address decode");

  chk_write_pol: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
    (ce && wr_en && hit_pol) |=> (pol_q == $past(wr_pol)))
    else $error("polarity write did not land");

  chk_write_oper: assert property (@(posedge pclk) disable iff (!presetn) // RULE14
    (ce && wr_en && hit_oper) |=> (oper_q == $past(wr_freq)))
    else $error("operator frequency write did not land");

  chk_cfg_no_write: assert property (@(posedge pclk) disable iff (!presetn) // RULE15
    !acc_done |=> ($stable(pol_q) && $stable(src_q) && $stable(oper_q) && $stable(func_q)))
    else $error("configuration changed without a completed write");

  chk_fwd_sel_reset: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
    $rose(presetn) |-> (func_q[FWD_IDX*FSEL_W +: FSEL_W] == FN_FORWARD_RUN))
    else $error("forward terminal not on forward run after reset");

  chk_reset_follow: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
    ce |=> (rst_q == $past(cmd.reset_req)))
    else $error("reset command not taken from decode");

  chk_active_follow: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
    ce |=> (act_q == $past(active)))
    else $error("terminal active state not taken from decode");

  chk_hold_frozen: assert property (@(posedge pclk) disable iff (!presetn) // RULE16
    s_frozen |=> ($stable(run_q) && $stable(idx_q) && $stable(freq_q) && $stable(pready_q)))
    else $error("state moved while clock enable was low");

endmodule : itrs_top

// [verification/itrs_contacts.sv]
`timescale 1ns/1ps
module itrs_contacts
  import itrs_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic [NTERM-1:0]  want_closed,
  input  wire logic [FREQ_W-1:0] want_freq,
  output logic      [NTERM-1:0]  terminal_closed,
  output logic      [FREQ_W-1:0] analog_freq
);
  ////////////////////////////////////////////////////////////////////////////
  // contacts start open at power-up, as a wired panel would
  initial terminal_closed = '0;
  initial analog_freq = '0;
  // contacts move just after an edge; a one-cycle command is a real bounce
  always @(posedge pclk) begin
    terminal_closed <= want_closed;
    analog_freq     <= want_freq;
  end
endmodule : itrs_contacts

// [verification/itrs_top_tb.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module itrs_top_tb;
  import itrs_pkg::*;
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              ce = 1'b1;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [AW-1:0]     paddr = '0;
  logic [31:0]       pwdata = '0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic [NTERM-1:0]  want_closed = '0;
  logic [FREQ_W-1:0] want_freq = '0;
  logic [NTERM-1:0]  terminal_closed;
  logic [FREQ_W-1:0] analog_freq;
  itrs_run_e         run_state;
  logic [3:0]        speed_index;
  logic [FREQ_W-1:0] freq_ref;
  logic              reset_cmd;
  logic [NTERM-1:0]  terminal_active;
  int                n_fail = 0;
  int                tests_run = 0;
  logic [31:0]       rq;
  logic              re;

  always #12.5 pclk = ~pclk;

  itrs_contacts u_contacts (.pclk(pclk), .want_closed(want_closed), .want_freq(want_freq),
    .terminal_closed(terminal_closed), .analog_freq(analog_freq));

  itrs_top u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .terminal_closed(terminal_closed), .analog_freq_in(analog_freq),
    .run_state(run_state), .speed_index(speed_index), .freq_ref(freq_ref),
    .reset_cmd(reset_cmd), .terminal_active(terminal_active));

  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict

  // one apb transfer; the request holds until pready is seen at an edge
  task automatic apb(input logic wr, input logic [AW-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rq = prdata;
    re = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_fail++;
      give_verdict();
    end
  endtask : apb

  // pin to run state takes six edges, to the reference seven; eight leaves margin
  task automatic contacts(input logic [NTERM-1:0] c);
    want_closed <= c;
    repeat (8) @(posedge pclk);
  endtask : contacts

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    apb(1'b0, OFS_POLARITY, '0);
    `CHK(rq, 32'h0000_0000)
    apb(1'b0, OFS_FWDFUNC, '0);
    `CHK(rq, 32'h0000_0000)
    apb(1'b0, OFS_FUNC, '0);
    `CHK(rq, 32'h0000_0011)
    `CHK(re, 1'b0)
    apb(1'b0, OFS_FUNC + 8'h1c, '0);
    `CHK(rq, 32'h0000_0001)
    apb(1'b1, OFS_FUNC + 8'h08, 32'h0000_0028);
    apb(1'b0, OFS_FUNC + 8'h08, '0);
    `CHK(rq, 32'h0000_0028)
    apb(1'b0, OFS_PRESET, '0);
    `CHK(re, 1'b1)
    $display("test regs done");
  endtask : t_regs

  task automatic t_run;
    contacts(9'h100);
    `CHK(run_state, RUN_FORWARD)
    `CHK(terminal_active, 9'h100)
    contacts(9'h000);
    `CHK(run_state, RUN_STOP)
    contacts(9'h080);
    `CHK(run_state, RUN_BACKWARD)
    contacts(9'h000);
    `CHK(run_state, RUN_STOP)
    contacts(9'h180);
    `CHK(run_state, RUN_STOP)
    apb(1'b1, OFS_FWDFUNC, 32'h0000_0001);
    contacts(9'h100);
    `CHK(run_state, RUN_BACKWARD)
    apb(1'b1, OFS_FWDFUNC, 32'h0000_0000);
    contacts(9'h000);
    $display("test run done");
  endtask : t_run

  task automatic t_closed_pol;
    apb(1'b1, OFS_POLARITY, 32'h0000_0100);
    contacts(9'h000);
    `CHK(run_state, RUN_FORWARD)
    `CHK(terminal_active, 9'h100)
    contacts(9'h100);
    `CHK(run_state, RUN_STOP)
    apb(1'b1, OFS_POLARITY, 32'h0000_0080);
    contacts(9'h000);
    `CHK(run_state, RUN_BACKWARD)
    `CHK(terminal_active, 9'h080)
    // reset-function input must ignore its polarity bit
    apb(1'b1, OFS_POLARITY, 32'h0000_0001);
    contacts(9'h000);
    `CHK(reset_cmd, 1'b0)
    contacts(9'h001);
    `CHK(reset_cmd, 1'b1)
    apb(1'b1, OFS_POLARITY, 32'h0000_0000);
    contacts(9'h000);
    $display("test polarity done");
  endtask : t_closed_pol

  task automatic t_speed;
    logic [15:0] e;
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, OFS_FUNC + 8'(4 * i), 32'(2 + i));
    end
    for (int k = 1; k < 16; k++) begin
      apb(1'b1, OFS_PRESET + 8'(4 * k), 32'(16'h1000 + 16'h0111 * k));
    end
    apb(1'b1, OFS_OPERFREQ, 32'h0000_0abc);
    apb(1'b1, OFS_SOURCE, 32'h0000_0000);
    for (int k = 0; k < 16; k++) begin
      e = (k == 0) ? 16'h0abc : 16'(16'h1000 + 16'h0111 * k);
      contacts(9'(k));
      `CHK(speed_index, 4'(k))
      `CHK(freq_ref, e)
    end
    apb(1'b0, OFS_STATUS, '0);
    `CHK(rq[7:4], 4'hf)
    apb(1'b0, OFS_FREQREF, '0);
    `CHK(rq, 32'h0000_1fff)
    want_freq <= 16'h4321;
    apb(1'b1, OFS_SOURCE, 32'h0000_0001);
    contacts(9'h000);
    `CHK(freq_ref, 16'h4321)
    apb(1'b1, OFS_SOURCE, 32'h0000_0000);
    repeat (8) @(posedge pclk);
    `CHK(freq_ref, 16'h0abc)
    $display("test speed done");
  endtask : t_speed

  task automatic t_glitch;
    want_closed <= 9'h100;
    @(posedge pclk);
    want_closed <= 9'h000;
    for (int i = 0; i < 8; i++) begin
      @(posedge pclk);
      `CHK(run_state, RUN_STOP)
    end
    $display("test glitch done");
  endtask : t_glitch

  task automatic t_freeze;
    contacts(9'h100);
    `CHK(run_state, RUN_FORWARD)
    ce <= 1'b0;
    contacts(9'h080);
    `CHK(run_state, RUN_FORWARD)
    ce <= 1'b1;
    contacts(9'h080);
    `CHK(run_state, RUN_BACKWARD)
    contacts(9'h000);
    $display("test freeze done");
  endtask : t_freeze

  task automatic t_reset;
    apb(1'b1, OFS_POLARITY, 32'h0000_0100);
    contacts(9'h000);
    `CHK(run_state, RUN_FORWARD)
    presetn <= 1'b0;
    @(posedge pclk);
    `CHK(run_state, RUN_STOP)
    `CHK(terminal_active, 9'h000)
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFS_POLARITY, '0);
    `CHK(rq, 32'h0000_0000)
    apb(1'b0, OFS_FUNC, '0);
    `CHK(rq, 32'h0000_0011)
    contacts(9'h100);
    `CHK(run_state, RUN_FORWARD)
    contacts(9'h000);
    $display("test reset done");
  endtask : t_reset

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_run();
    t_closed_pol();
    t_glitch();
    t_freeze();
    t_speed();
    t_reset();
    give_verdict();
  end
endmodule : itrs_top_tb
